// ==== hdl/sadc_pkg.sv ====
// Package with shared timing constants, states and codes for the converter control link.
package sadc_pkg;

  // ----------------------------------------------------------------
  // Timing figures and derived cycle counts at 200 MHz.
  // ----------------------------------------------------------------
  localparam int CLK_PS = 5000;
  localparam int CONV_PULSE_MIN_NS = 40;
  localparam int CONV_PULSE_MAX_NS = 7000;
  localparam int SEL_SETUP_NS = 10;
  localparam int CONV_TIME_NS = 7600;
  localparam int DATA_VALID_MAX_NS = 8000;
  localparam int BUSY_AFTER_DATA_NS = 50;
  localparam int OLD_DATA_NS = 7000;
  localparam int CONV_SPACING_NS = 10000;
  localparam int CONV_PULSE_MIN_CYC = (CONV_PULSE_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CONV_PULSE_MAX_CYC = (CONV_PULSE_MAX_NS * 1000) / CLK_PS;
  localparam int SEL_SETUP_CYC = (SEL_SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int CONV_TIME_CYC = (CONV_TIME_NS * 1000) / CLK_PS;
  localparam int DATA_VALID_MAX_CYC = (DATA_VALID_MAX_NS * 1000) / CLK_PS;
  localparam int BUSY_AFTER_DATA_CYC = (BUSY_AFTER_DATA_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int OLD_DATA_CYC = (OLD_DATA_NS * 1000) / CLK_PS;
  localparam int CONV_SPACING_CYC = (CONV_SPACING_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int TIMEOUT_CYC = DATA_VALID_MAX_CYC + CONV_PULSE_MAX_CYC;
  localparam int CNT_W = 13;

  // ----------------------------------------------------------------
  // Reset values and result codes.
  // ----------------------------------------------------------------
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [15:0] CODE_POS_FULL = 16'h7FFF;
  localparam logic [15:0] CODE_NEG_FULL = 16'h8000;

  typedef enum logic [1:0] {
    SADC_DEV_IDLE = 2'b00,
    SADC_DEV_CONV = 2'b01,
    SADC_DEV_DONE = 2'b10
  } sadc_dev_state_t;

  typedef enum logic [2:0] {
    SADC_HST_IDLE = 3'b000,
    SADC_HST_SETUP = 3'b001,
    SADC_HST_PULSE = 3'b010,
    SADC_HST_WAIT = 3'b011,
    SADC_HST_RDHI = 3'b100,
    SADC_HST_RDLO = 3'b101,
    SADC_HST_GAP = 3'b110
  } sadc_host_state_t;

  // Saturating clamp of a signed sample into the 16-bit result code.
  function automatic logic [15:0] sadc_clamp(input logic signed [17:0] v);
    if (v > 18'sd32767) begin
      sadc_clamp = CODE_POS_FULL;
    end else if (v < -18'sd32768) begin
      sadc_clamp = CODE_NEG_FULL;
    end else begin
      sadc_clamp = v[15:0];
    end
  endfunction

endpackage

// ==== hdl/sadc_if.sv ====
// Interface carrying the pins between host controller and converter.
`timescale 1ns/100ps
interface sadc_if;
  logic cs_n;
  logic rd_conv;
  logic byte_sel;
  logic busy_n;
  logic [7:0] result_bus_o;
  logic result_bus_oe_n;

  modport dev (
    input cs_n,
    input rd_conv,
    input byte_sel,
    output busy_n,
    output result_bus_o,
    output result_bus_oe_n
  );

  modport host (
    output cs_n,
    output rd_conv,
    output byte_sel,
    input busy_n,
    input result_bus_o,
    input result_bus_oe_n
  );
endinterface

// ==== hdl/sadc_sync.sv ====
// Two-flop synchroniser for pin inputs.
`timescale 1ns/100ps
module sadc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // First stage feeds only the second stage.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ==== hdl/sadc_dev.sv ====
// Converter end: start detection, busy, result register and byte-wide output bus.
`timescale 1ns/100ps
module sadc_dev (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Pins toward the host.
  sadc_if.dev pins,
  // Sample source standing in for the analog front end.
  input wire logic signed [17:0] sample_in,
  // Status.
  output logic busy_o,
  output logic [15:0] result_o
);

  typedef struct packed {
    sadc_pkg::sadc_dev_state_t st;
    logic [12:0] cnt;
    logic [15:0] held;
    logic [15:0] result;
    logic busy_n;
    logic [7:0] bus;
    logic oe_n;
  } sadc_dev_reg_t;

  sadc_dev_reg_t s_reg;
  sadc_dev_reg_t s_next;
  logic [2:0] pin_s;
  logic start_lvl;
  logic bus_en;
  logic [15:0] shown;

  sadc_sync #(.W(3)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d({!pins.cs_n, !pins.rd_conv, pins.byte_sel}),
    .q(pin_s)
  );

  // Both lines low is the start level; either may fall first.
  // The strobes pass the synchroniser as active-high levels, so its cleared state reads as idle and not as a start.
  assign start_lvl = pin_s[2] && pin_s[1];
  assign bus_en = pin_s[2] && !pin_s[1];
  // Old data stays readable early in a conversion; from OLD_DATA_CYC on the bus shows the held new word, before it lands in result.
  assign shown = (s_reg.st == sadc_pkg::SADC_DEV_CONV && s_reg.cnt >= 13'(sadc_pkg::OLD_DATA_CYC)) ?
                 s_reg.held : s_reg.result;

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.oe_n = !bus_en;
    s_next.bus = pin_s[0] ? shown[7:0] : shown[15:8];
    case (s_reg.st)
      sadc_pkg::SADC_DEV_IDLE: begin
        if (start_lvl) begin
          s_next.st = sadc_pkg::SADC_DEV_CONV;
          s_next.busy_n = 1'b0;
          s_next.cnt = '0;
          s_next.held = sadc_pkg::sadc_clamp(sample_in);
        end
      end
      sadc_pkg::SADC_DEV_CONV: begin
        // Start levels are ignored here.
        s_next.cnt = s_reg.cnt + 13'd1;
        if (s_reg.cnt == 13'(sadc_pkg::CONV_TIME_CYC - sadc_pkg::BUSY_AFTER_DATA_CYC)) begin
          s_next.result = s_reg.held;
        end
        if (s_reg.cnt == 13'(sadc_pkg::CONV_TIME_CYC)) begin
          s_next.st = sadc_pkg::SADC_DEV_DONE;
          s_next.busy_n = 1'b1;
        end
      end
      sadc_pkg::SADC_DEV_DONE: begin
        // Tracking resumes; a start still held low restarts from idle one cycle later, taking a fresh sample into held.
        s_next.st = sadc_pkg::SADC_DEV_IDLE;
      end
      default: begin
        s_next.st = sadc_pkg::SADC_DEV_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s_reg <= '{st: sadc_pkg::SADC_DEV_IDLE, cnt: '0, held: sadc_pkg::RESULT_RESET,
                 result: sadc_pkg::RESULT_RESET, busy_n: 1'b1, bus: 8'h00, oe_n: 1'b1};
    end else begin
      s_reg <= s_next;
    end
  end

  assign pins.busy_n = s_reg.busy_n;
  assign pins.result_bus_o = s_reg.bus;
  assign pins.result_bus_oe_n = s_reg.oe_n;
  assign busy_o = !s_reg.busy_n;
  assign result_o = s_reg.result;

endmodule

// ==== hdl/sadc_host.sv ====
// Host end: issues conversions, waits for busy, reads both bytes.
`timescale 1ns/100ps
module sadc_host (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Pins toward the converter.
  sadc_if.host pins,
  // User side.
  input wire logic start_i,
  output logic done_o,
  output logic error_o,
  output logic [15:0] data_o
);

  typedef struct packed {
    sadc_pkg::sadc_host_state_t st;
    logic [12:0] cnt;
    logic cs_n;
    logic rd_conv;
    logic byte_sel;
    logic [15:0] data;
    logic done;
    logic err;
  } sadc_host_reg_t;

  sadc_host_reg_t h_reg;
  sadc_host_reg_t h_next;
  logic [8:0] in_s;

  sadc_sync #(.W(9)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .d({pins.busy_n, pins.result_bus_o}),
    .q(in_s)
  );

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    h_next = h_reg;
    h_next.done = 1'b0;
    h_next.cnt = h_reg.cnt + 13'd1;
    case (h_reg.st)
      sadc_pkg::SADC_HST_IDLE: begin
        if (start_i && in_s[8]) begin
          h_next.st = sadc_pkg::SADC_HST_SETUP;
          h_next.rd_conv = 1'b0;
          h_next.cnt = '0;
          h_next.err = 1'b0;
        end
      end
      sadc_pkg::SADC_HST_SETUP: begin
        if (h_reg.cnt == 13'(sadc_pkg::SEL_SETUP_CYC)) begin
          h_next.cs_n = 1'b0;
          h_next.st = sadc_pkg::SADC_HST_PULSE;
          h_next.cnt = '0;
        end
      end
      sadc_pkg::SADC_HST_PULSE: begin
        if (h_reg.cnt == 13'(sadc_pkg::CONV_PULSE_MIN_CYC)) begin
          h_next.cs_n = 1'b1;
          h_next.rd_conv = 1'b1;
          h_next.st = sadc_pkg::SADC_HST_WAIT;
          h_next.cnt = '0;
        end
      end
      sadc_pkg::SADC_HST_WAIT: begin
        // Bus stays untouched during conversion to keep noise out.
        if (in_s[8] && h_reg.cnt > 13'd4) begin
          h_next.st = sadc_pkg::SADC_HST_RDHI;
          h_next.cs_n = 1'b0;
          h_next.byte_sel = 1'b0;
          h_next.cnt = '0;
        end else if (h_reg.cnt == 13'(sadc_pkg::TIMEOUT_CYC)) begin
          h_next.err = 1'b1;
          h_next.st = sadc_pkg::SADC_HST_GAP;
          h_next.cnt = '0;
        end
      end
      sadc_pkg::SADC_HST_RDHI: begin
        // Byte settle covers pin delay, device register and our sync.
        if (h_reg.cnt == 13'd6) begin
          h_next.data[15:8] = in_s[7:0];
          h_next.byte_sel = 1'b1;
          h_next.st = sadc_pkg::SADC_HST_RDLO;
          h_next.cnt = '0;
        end
      end
      sadc_pkg::SADC_HST_RDLO: begin
        if (h_reg.cnt == 13'd6) begin
          h_next.data[7:0] = in_s[7:0];
          h_next.cs_n = 1'b1;
          h_next.done = 1'b1;
          h_next.st = sadc_pkg::SADC_HST_GAP;
        end
      end
      sadc_pkg::SADC_HST_GAP: begin
        // Spacing between requests lets acquisition settle.
        if (h_reg.cnt >= 13'(sadc_pkg::CONV_SPACING_CYC)) begin
          h_next.st = sadc_pkg::SADC_HST_IDLE;
        end
      end
      default: begin
        h_next.st = sadc_pkg::SADC_HST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      h_reg <= '{st: sadc_pkg::SADC_HST_IDLE, cnt: '0, cs_n: 1'b1, rd_conv: 1'b1, byte_sel: 1'b0,
                 data: sadc_pkg::RESULT_RESET, done: 1'b0, err: 1'b0};
    end else begin
      h_reg <= h_next;
    end
  end

  assign pins.cs_n = h_reg.cs_n;
  assign pins.rd_conv = h_reg.rd_conv;
  assign pins.byte_sel = h_reg.byte_sel;
  assign done_o = h_reg.done;
  assign error_o = h_reg.err;
  assign data_o = h_reg.data;

endmodule

// ==== test/sadc_checker.sv ====
// Checker for the pin protocol between the host end and the converter end.
`timescale 1ns/100ps
module sadc_checker (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset,
  // Control pins from the host.
  input wire logic cs_n,
  input wire logic rd_conv,
  input wire logic byte_sel,
  // Pins from the converter.
  input wire logic busy_n,
  input wire logic [7:0] result_bus_o,
  input wire logic result_bus_oe_n
);
  // ----------------------------------------------------------------
  // Helper logic.
  // ----------------------------------------------------------------
  localparam int GAP_MIN = 2000;
  logic [11:0] gap_reg;
  logic [10:0] req_len_reg;
  logic [10:0] busy_len_reg;
  logic req;

  // Both control lines low form a convert request.
  assign req = !cs_n && !rd_conv;

  // Cycles since busy last fell; saturates high so the first start after reset is legal.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gap_reg <= 12'hFFF;
    end else if ($fell(busy_n)) begin
      gap_reg <= 12'h000;
    end else if (gap_reg != 12'hFFF) begin
      gap_reg <= gap_reg + 12'h001;
    end
  end

  // Run lengths of a held request and of a low busy; saturating counters stand in for long delay ranges.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      req_len_reg <= 11'h000;
      busy_len_reg <= 11'h000;
    end else begin
      if (!req) begin
        req_len_reg <= 11'h000;
      end else if (req_len_reg != 11'h7FF) begin
        req_len_reg <= req_len_reg + 11'h001;
      end
      if (busy_n) begin
        busy_len_reg <= 11'h000;
      end else if (busy_len_reg != 11'h7FF) begin
        busy_len_reg <= busy_len_reg + 11'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);

  // The pin enable lags the control lines by three cycles, so the check looks back that far.
  AST_BUS_DESELECT: assert property ($past(cs_n, 3) |-> result_bus_oe_n)
    else $error("bus driven while deselected");
  AST_BUS_CONVERT: assert property (!$past(rd_conv, 3) |-> result_bus_oe_n)
    else $error("bus driven while convert line low");
  AST_BUSY_FALL: assert property ($rose(req) && busy_n |-> ##[1:13] !busy_n)
    else $error("busy late after convert request");
  AST_BUSY_HOLD: assert property ($fell(busy_n) |=> !busy_n [*8])
    else $error("busy rose too soon");
  AST_DATA_BOUND: assert property (busy_len_reg <= 11'(sadc_pkg::DATA_VALID_MAX_CYC))
    else $error("conversion longer than the data valid limit");
  AST_RELEASE: assert property ($rose(busy_n) |-> cs_n || rd_conv)
    else $error("request still low when busy rose");
  AST_PULSE_MIN: assert property ($fell(cs_n) && !rd_conv |-> req [*8])
    else $error("convert pulse shorter than minimum");
  AST_PULSE_MAX: assert property (req_len_reg <= 11'(sadc_pkg::CONV_PULSE_MAX_CYC))
    else $error("convert pulse longer than maximum");
  AST_SETUP: assert property ($fell(cs_n) && !rd_conv |-> !$past(rd_conv, 2))
    else $error("convert line setup before select too short");
  AST_SPACING: assert property ($fell(busy_n) |-> gap_reg >= GAP_MIN)
    else $error("conversions spaced too closely");
  AST_BYTE_STABLE: assert property ((!result_bus_oe_n && $stable(byte_sel)) [*6] |-> $stable(result_bus_o))
    else $error("byte lanes moved without a byte select change");

  // Coverage of a byte swap while the bus is driven.
  cover property ($rose(byte_sel) && !result_bus_oe_n);
endmodule

// ==== test/test_sar_adc_convert_read_control.sv ====
// Self-checking bench joining the host end and the converter end.
`timescale 1ns/100ps
module test_sar_adc_convert_read_control;
  // ----------------------------------------------------------------
  // Signals and table of conversions.
  // ----------------------------------------------------------------
  typedef struct {
    logic signed [17:0] smp;
    logic [15:0] exp;
  } sadc_row_t;

  localparam int TIMEOUT_LIM = 40000;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic start_i = 1'b0;
  logic signed [17:0] sample_in = 18'sh00000;
  logic busy_o;
  logic [15:0] result_o;
  logic done_o;
  logic error_o;
  logic [15:0] data_o;
  int err_count = 0;
  int checks = 0;
  int cycles = 0;
  // Codes beyond full scale must clamp; small values map straight through.
  sadc_row_t rows [5] = '{'{18'sh08000, 16'h7FFF}, '{-18'sh08001, 16'h8000},
    '{18'sh00000, 16'h0000}, '{-18'sh00001, 16'hFFFF}, '{18'sh01234, 16'h1234}};

  // ----------------------------------------------------------------
  // Design ends and checker.
  // ----------------------------------------------------------------
  sadc_if link();
  sadc_dev u_sadc_dev (.sys_clk(sys_clk), .reset(reset), .pins(link), .sample_in(sample_in),
    .busy_o(busy_o), .result_o(result_o));
  sadc_host u_sadc_host (.sys_clk(sys_clk), .reset(reset), .pins(link), .start_i(start_i),
    .done_o(done_o), .error_o(error_o), .data_o(data_o));
  sadc_checker u_sadc_checker (.sys_clk(sys_clk), .reset(reset), .cs_n(link.cs_n), .rd_conv(link.rd_conv),
    .byte_sel(link.byte_sel), .busy_n(link.busy_n), .result_bus_o(link.result_bus_o),
    .result_bus_oe_n(link.result_bus_oe_n));

  // Clock at 200 MHz.
  always #2.5 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Tasks.
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One pulse on the request; the host is only listening in idle, so the gap wait follows.
  // The host sees busy through two flip-flops, so a request right after reset release would be lost.
  task automatic pulse_start(input logic signed [17:0] smp);
    repeat (4) @(negedge sys_clk);
    sample_in = smp;
    start_i = 1'b1;
    @(negedge sys_clk);
    start_i = 1'b0;
  endtask

  task automatic convert(input logic signed [17:0] smp, input logic [15:0] exp);
    int n = 0;
    pulse_start(smp);
    repeat (20) @(negedge sys_clk);
    check({15'h0000, busy_o}, 16'h0001);
    while (done_o !== 1'b1 && n < 5000) begin
      @(negedge sys_clk);
      n++;
    end
    check({15'h0000, done_o}, 16'h0001);
    check(data_o, exp);
    check(result_o, exp);
    check({15'h0000, error_o}, 16'h0000);
    repeat (2100) @(negedge sys_clk);
  endtask

  // Pin levels at rest: deselected, read mode, not busy, bus released.
  task automatic check_idle;
    check({12'h000, link.cs_n, link.rd_conv, link.busy_n, link.result_bus_oe_n}, 16'h000F);
    check(data_o, 16'h0000);
  endtask

  // ----------------------------------------------------------------
  // Hang guard.
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == TIMEOUT_LIM) begin
      err_count++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(negedge sys_clk);
    check_idle();
    reset = 1'b0;
    foreach (rows[i]) begin
      convert(rows[i].smp, rows[i].exp);
    end
    // Reset in mid-conversion must abort it and return the pins to rest.
    pulse_start(18'sh00100);
    repeat (100) @(negedge sys_clk);
    check({15'h0000, busy_o}, 16'h0001);
    reset = 1'b1;
    @(negedge sys_clk);
    check_idle();
    reset = 1'b0;
    // Exact positive full scale after the abort.
    convert(18'sh07FFF, 16'h7FFF);
    stop_test;
  end
endmodule
